//--- verilog/oscillator_tuning_config.v
// Oscillator configuration registers, tuning word staging and accumulator
`timescale 1ns/100ps
`default_nettype none
`include "osc_tuning_consts.vh"
module oscillator_tuning_config (
	input wire ref_clk_i,
	input wire rst_i,
	input wire reg_wr_i,
	input wire reg_rd_i,
	input wire [11:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	output reg [7:0] reg_rdata_o,
	output reg reg_hit_o,
	output reg oscillator_enable_o,
	output reg sinx_comp_enable_o,
	output reg filter_bandwidth_sel_o,
	output reg modulus_mode_enable_o,
	output reg sideband_select_o,
	output reg halfband_interp_enable_o,
	output reg tone_only_enable_o,
	output reg [15:0] tone_amplitude_o,
	output reg [47:0] active_tuning_word_o,
	output reg [47:0] phase_o
);
	reg [7:0] tone_only_select;
	reg [7:0] datapath_control;
	reg [7:0] tuning_word_load_request;
	reg [7:0] tuning_word_byte0;
	reg [7:0] tuning_word_byte1;
	reg [7:0] tuning_word_byte2;
	reg [7:0] tuning_word_byte3;
	reg [7:0] tuning_word_byte4;
	reg [7:0] tuning_word_byte5;
	reg [7:0] tone_source_control;
	reg [7:0] tone_amplitude_high;
	reg [7:0] tone_amplitude_low;
	reg [47:0] next_phase;
	reg [7:0] next_rdata;
	reg next_hit;
	reg next_req_rise;
	wire wr_only_sel;
	wire wr_dp_sel;
	wire wr_req_sel;
	wire wr_byte0_sel;
	wire wr_byte1_sel;
	wire wr_byte2_sel;
	wire wr_byte3_sel;
	wire wr_byte4_sel;
	wire wr_byte5_sel;
	wire wr_amp_high_sel;
	wire wr_amp_low_sel;
	wire wr_src_sel;

	// Write strobe aimed at one register address
	function wr_strobe;
		input wr;
		input [11:0] addr;
		input [11:0] target;
		begin
			wr_strobe = wr && addr == target;
		end
	endfunction

	// One write strobe per register, unmapped writes hit none
	assign wr_only_sel =
		wr_strobe(reg_wr_i, reg_addr_i, `ADDR_TONE_ONLY_SELECT);
	assign wr_dp_sel =
		wr_strobe(reg_wr_i, reg_addr_i, `ADDR_DATAPATH_CONTROL);
	assign wr_req_sel =
		wr_strobe(reg_wr_i, reg_addr_i, `ADDR_TW_LOAD_REQUEST);
	assign wr_byte0_sel =
		wr_strobe(reg_wr_i, reg_addr_i, `ADDR_TW_BYTE0);
	assign wr_byte1_sel =
		wr_strobe(reg_wr_i, reg_addr_i, `ADDR_TW_BYTE1);
	assign wr_byte2_sel =
		wr_strobe(reg_wr_i, reg_addr_i, `ADDR_TW_BYTE2);
	assign wr_byte3_sel =
		wr_strobe(reg_wr_i, reg_addr_i, `ADDR_TW_BYTE3);
	assign wr_byte4_sel =
		wr_strobe(reg_wr_i, reg_addr_i, `ADDR_TW_BYTE4);
	assign wr_byte5_sel =
		wr_strobe(reg_wr_i, reg_addr_i, `ADDR_TW_BYTE5);
	assign wr_amp_high_sel =
		wr_strobe(reg_wr_i, reg_addr_i, `ADDR_TONE_AMP_HIGH);
	assign wr_amp_low_sel =
		wr_strobe(reg_wr_i, reg_addr_i, `ADDR_TONE_AMP_LOW);
	assign wr_src_sel =
		wr_strobe(reg_wr_i, reg_addr_i, `ADDR_TONE_SOURCE_CONTROL);

	// Tone-only select, stored with no side effect
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tone_only_select <= `RESET_BYTE;
		end else if (wr_only_sel) begin
			tone_only_select <= reg_wdata_i;
		end
	end

	// Datapath options, reserved positions kept zero
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			datapath_control <= `RESET_BYTE;
		end else if (wr_dp_sel) begin
			datapath_control <= reg_wdata_i & ~`DATAPATH_RESERVED_MASK;
		end
	end

	// Load request, its rising edge commits the word
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tuning_word_load_request <= `RESET_BYTE;
		end else if (wr_req_sel) begin
			tuning_word_load_request <= reg_wdata_i;
		end
	end

	// Staging byte 0, word bits 7 to 0
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tuning_word_byte0 <= `RESET_BYTE;
		end else if (wr_byte0_sel) begin
			tuning_word_byte0 <= reg_wdata_i;
		end
	end

	// Staging byte 1, word bits 15 to 8
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tuning_word_byte1 <= `RESET_BYTE;
		end else if (wr_byte1_sel) begin
			tuning_word_byte1 <= reg_wdata_i;
		end
	end

	// Staging byte 2, word bits 23 to 16
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tuning_word_byte2 <= `RESET_BYTE;
		end else if (wr_byte2_sel) begin
			tuning_word_byte2 <= reg_wdata_i;
		end
	end

	// Staging byte 3, word bits 31 to 24
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tuning_word_byte3 <= `RESET_BYTE;
		end else if (wr_byte3_sel) begin
			tuning_word_byte3 <= reg_wdata_i;
		end
	end

	// Staging byte 4, word bits 39 to 32
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tuning_word_byte4 <= `RESET_BYTE;
		end else if (wr_byte4_sel) begin
			tuning_word_byte4 <= reg_wdata_i;
		end
	end

	// Staging byte 5, word bits 47 to 40
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tuning_word_byte5 <= `RESET_BYTE;
		end else if (wr_byte5_sel) begin
			tuning_word_byte5 <= reg_wdata_i;
		end
	end

	// Tone amplitude, upper byte
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tone_amplitude_high <= `RESET_BYTE;
		end else if (wr_amp_high_sel) begin
			tone_amplitude_high <= reg_wdata_i;
		end
	end

	// Tone amplitude, lower byte
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tone_amplitude_low <= `RESET_BYTE;
		end else if (wr_amp_low_sel) begin
			tone_amplitude_low <= reg_wdata_i;
		end
	end

	// Tone source, bit 1 picks tone-only output
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tone_source_control <= `RESET_BYTE;
		end else if (wr_src_sel) begin
			tone_source_control <= reg_wdata_i;
		end
	end

	// Request goes from low to high with this write
	always @* begin
		next_req_rise = wr_req_sel &&
			reg_wdata_i[`BIT_LOAD_REQUEST] &&
			!tuning_word_load_request[`BIT_LOAD_REQUEST];
	end

	// Next phase, wraps at 48 bits
	always @* begin
		next_phase = phase_o + active_tuning_word_o;
	end

	// Staged bytes reach the oscillator only on a request edge
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			active_tuning_word_o <= `RESET_TW;
		end else if (next_req_rise) begin
			active_tuning_word_o <= {tuning_word_byte5, tuning_word_byte4,
				tuning_word_byte3, tuning_word_byte2, tuning_word_byte1,
				tuning_word_byte0};
		end
	end

	// Accumulator steps only while enabled, holds otherwise
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			phase_o <= `RESET_TW;
		end else if (datapath_control[`BIT_OSCILLATOR_ENABLE]) begin
			phase_o <= next_phase;
		end
	end

	// Read mux, unmapped addresses answer zero without a hit
	always @* begin
		next_hit = 1'b1;
		case (reg_addr_i)
			`ADDR_TONE_ONLY_SELECT: next_rdata = tone_only_select;
			`ADDR_DATAPATH_CONTROL: next_rdata = datapath_control;
			`ADDR_TW_LOAD_REQUEST: next_rdata = tuning_word_load_request;
			`ADDR_TW_BYTE0: next_rdata = tuning_word_byte0;
			`ADDR_TW_BYTE1: next_rdata = tuning_word_byte1;
			`ADDR_TW_BYTE2: next_rdata = tuning_word_byte2;
			`ADDR_TW_BYTE3: next_rdata = tuning_word_byte3;
			`ADDR_TW_BYTE4: next_rdata = tuning_word_byte4;
			`ADDR_TW_BYTE5: next_rdata = tuning_word_byte5;
			`ADDR_TONE_AMP_HIGH: next_rdata = tone_amplitude_high;
			`ADDR_TONE_AMP_LOW: next_rdata = tone_amplitude_low;
			`ADDR_TONE_SOURCE_CONTROL: next_rdata = tone_source_control;
			default: begin
				next_rdata = `RESET_BYTE;
				next_hit = 1'b0;
			end
		endcase
	end

	// Read answer, one cycle after the strobe
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			reg_rdata_o <= `RESET_BYTE;
			reg_hit_o <= 1'b0;
		end else begin
			reg_rdata_o <= reg_rd_i ? next_rdata : `RESET_BYTE;
			reg_hit_o <= reg_rd_i & next_hit;
		end
	end

	// Datapath option outputs, one cycle behind the register
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			oscillator_enable_o <= 1'b0;
			sinx_comp_enable_o <= 1'b0;
			filter_bandwidth_sel_o <= 1'b0;
			modulus_mode_enable_o <= 1'b0;
			sideband_select_o <= 1'b0;
			halfband_interp_enable_o <= 1'b0;
		end else begin
			oscillator_enable_o <= datapath_control[`BIT_OSCILLATOR_ENABLE];
			sinx_comp_enable_o <= datapath_control[`BIT_SINX_COMP_ENABLE];
			filter_bandwidth_sel_o <=
				datapath_control[`BIT_FILTER_BANDWIDTH_SEL];
			modulus_mode_enable_o <=
				datapath_control[`BIT_MODULUS_MODE_ENABLE];
			sideband_select_o <= datapath_control[`BIT_SIDEBAND_SELECT];
			halfband_interp_enable_o <=
				datapath_control[`BIT_HALFBAND_INTERP_ENABLE];
		end
	end

	// Tone source and amplitude outputs
	always @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			tone_only_enable_o <= 1'b0;
			tone_amplitude_o <= 16'h0000;
		end else begin
			tone_only_enable_o <=
				tone_source_control[`BIT_TONE_ONLY_ENABLE];
			tone_amplitude_o <= {tone_amplitude_high, tone_amplitude_low};
		end
	end
endmodule
`default_nettype wire

//--- verilog/osc_tuning_consts.vh
// Register offsets, field positions and reset values of the oscillator block
`ifndef OSC_TUNING_CONSTS_VH
`define OSC_TUNING_CONSTS_VH
`define ADDR_TONE_ONLY_SELECT 12'h0110
`define ADDR_DATAPATH_CONTROL 12'h0111
`define ADDR_TW_LOAD_REQUEST 12'h0113
`define ADDR_TW_BYTE0 12'h0114
`define ADDR_TW_BYTE1 12'h0115
`define ADDR_TW_BYTE2 12'h0116
`define ADDR_TW_BYTE3 12'h0117
`define ADDR_TW_BYTE4 12'h0118
`define ADDR_TW_BYTE5 12'h0119
`define ADDR_TONE_AMP_HIGH 12'h014e
`define ADDR_TONE_AMP_LOW 12'h014f
`define ADDR_TONE_SOURCE_CONTROL 12'h0150
`define BIT_SINX_COMP_ENABLE 7
`define BIT_OSCILLATOR_ENABLE 6
`define BIT_FILTER_BANDWIDTH_SEL 4
`define BIT_MODULUS_MODE_ENABLE 2
`define BIT_SIDEBAND_SELECT 1
`define BIT_HALFBAND_INTERP_ENABLE 0
`define DATAPATH_RESERVED_MASK 8'h28
`define BIT_TONE_ONLY_ENABLE 1
`define BIT_LOAD_REQUEST 0
`define RESET_BYTE 8'h00
`define RESET_TW 48'h0000_0000_0000
`endif

//--- sim/osc_props.sv
// Port assertions of the oscillator block
`timescale 1ns/100ps
`default_nettype none
module osc_props (
	input wire ref_clk_i,
	input wire rst_i,
	input wire reg_wr_i,
	input wire [11:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire oscillator_enable_o,
	input wire sinx_comp_enable_o,
	input wire tone_only_enable_o,
	input wire [15:0] tone_amplitude_o,
	input wire [47:0] active_tuning_word_o,
	input wire [47:0] phase_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	// Config outputs follow writes two edges on
	a_osc_enable: assert property (reg_wr_i && reg_addr_i == 12'h0111
		|-> ##2 oscillator_enable_o == $past(reg_wdata_i[6], 2)) else $error("en");
	a_sinx_bit: assert property (reg_wr_i && reg_addr_i == 12'h0111
		|-> ##2 sinx_comp_enable_o == $past(reg_wdata_i[7], 2)) else $error("sinx");
	a_tone_src: assert property (reg_wr_i && reg_addr_i == 12'h0150
		|-> ##2 tone_only_enable_o == $past(reg_wdata_i[1], 2)) else $error("src");
	a_amp_high: assert property (reg_wr_i && reg_addr_i == 12'h014e
		|-> ##2 tone_amplitude_o[15:8] == $past(reg_wdata_i, 2)) else $error("hi");
	a_amp_low: assert property (reg_wr_i && reg_addr_i == 12'h014f
		|-> ##2 tone_amplitude_o[7:0] == $past(reg_wdata_i, 2)) else $error("lo");
	// Word changes only by a load request
	a_no_load: assert property (reg_wr_i && reg_addr_i == 12'h0113
		&& !reg_wdata_i[0] |=> $stable(active_tuning_word_o)) else $error("ld");
	a_commit_cause: assert property ($changed(active_tuning_word_o)
		|-> $past(reg_wr_i && reg_addr_i == 12'h0113)) else $error("cm");
	a_phase_step: assert property (oscillator_enable_o [*3] |-> phase_o
		== $past(phase_o) + $past(active_tuning_word_o)) else $error("ph");
	// Accumulator holds while disabled
	a_phase_hold: assert property (!oscillator_enable_o
		|-> $stable(phase_o)) else $error("hold");
endmodule
`default_nettype wire

//--- sim/host_model.sv
// Host side of the register port
`timescale 1ns/100ps
`default_nettype none
module host_model (
	input wire ref_clk_i,
	output logic wr_o,
	output logic rd_o,
	output logic [11:0] addr_o,
	output logic [7:0] wdata_o
);
	initial {wr_o, rd_o, addr_o, wdata_o} = 0;
	// One write, data inverted once released
	task wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge ref_clk_i);
		#1 {wr_o, addr_o, wdata_o} = {1'b1, a, d};
		@(posedge ref_clk_i);
		#1 {wr_o, wdata_o} = {1'b0, ~d};
	endtask
	// One read strobe
	task rd(input logic [11:0] a);
		@(posedge ref_clk_i);
		#1 {rd_o, addr_o} = {1'b1, a};
		@(posedge ref_clk_i);
		#1 rd_o = 0;
	endtask
endmodule
`default_nettype wire

//--- sim/tb.sv
// Testbench of the oscillator block
`timescale 1ns/100ps
`default_nettype none
module tb;
	logic ref_clk_i, rst_i, reg_wr_i, reg_rd_i, reg_hit_o, oscillator_enable_o;
	logic sinx_comp_enable_o, filter_bandwidth_sel_o, modulus_mode_enable_o;
	logic sideband_select_o, halfband_interp_enable_o, tone_only_enable_o;
	logic [11:0] reg_addr_i;
	logic [7:0] reg_wdata_i, reg_rdata_o;
	logic [15:0] tone_amplitude_o;
	logic [47:0] active_tuning_word_o, phase_o, p;
	int fails = 0;
	int comparisons = 0;
	host_model host (.ref_clk_i(ref_clk_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i),
		.addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
	oscillator_tuning_config i_oscillator_tuning_config (.*);
	task chk(input logic [47:0] g, input logic [47:0] e);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: %h not %h", $time, g, e);
		end
	endtask
	task stop_test;
		$display("fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Clock and watchdog
	initial begin
		ref_clk_i = 0;
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end
	initial begin
		#20000;
		fails++;
		stop_test;
	end
	// Configure, load word, run and read back
	initial begin
		rst_i = 1;
		repeat (3) @(posedge ref_clk_i);
		#1 rst_i = 0;
		chk(phase_o, 0);
		host.wr(12'h0110, 8'h80);
		host.wr(12'h0150, 8'h02);
		host.wr(12'h014e, 8'h12);
		host.wr(12'h014f, 8'h34);
		host.wr(12'h0113, 8'h00);
		for (int i = 0; i < 6; i++) host.wr(12'(12'h0119 - i), 8'(i + 1));
		host.wr(12'h0111, 8'hd7);
		chk(active_tuning_word_o, 0);
		host.wr(12'h0113, 8'h01);
		chk(active_tuning_word_o, 48'h0102_0304_0506);
		chk({sinx_comp_enable_o, oscillator_enable_o, filter_bandwidth_sel_o,
			modulus_mode_enable_o, sideband_select_o, halfband_interp_enable_o,
			tone_only_enable_o, tone_amplitude_o}, 23'h7f_1234);
		p = phase_o;
		@(posedge ref_clk_i);
		#1 chk(phase_o, p + 48'h0102_0304_0506);
		host.wr(12'h0113, 8'h00);
		host.wr(12'h0114, 8'hff);
		chk(active_tuning_word_o, 48'h0102_0304_0506);
		host.wr(12'h0113, 8'h01);
		chk(active_tuning_word_o, 48'h0102_0304_05ff);
		host.rd(12'h0111);
		chk({reg_hit_o, reg_rdata_o}, 9'h1d7);
		host.rd(12'h0112);
		chk({reg_hit_o, reg_rdata_o}, 0);
		host.wr(12'h0111, 8'h97);
		p = phase_o;
		host.wr(12'h0150, 8'h00);
		@(posedge ref_clk_i);
		#1 chk({oscillator_enable_o, tone_only_enable_o}, 0);
		chk(phase_o, p);
		stop_test;
	end
endmodule
bind oscillator_tuning_config osc_props i_props (.*);
`default_nettype wire
